/* rtl/pms_defines.svh */
// Constants of the power sequencer and its serial register port.
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

`define PMS_SLAVE_ADDR 7'h60

`define PMS_OFS_ISR 8'h02
`define PMS_OFS_SYS 8'h07
`define PMS_OFS_EN 8'h10
`define PMS_OFS_STAT 8'h11
`define PMS_OFS_VCC 8'h20
`define PMS_OFS_BUCK1_TARGET_VOLTAGE_1 8'h23
`define PMS_OFS_BUCK1_TARGET_VOLTAGE_2 8'h24
`define PMS_OFS_BUCK1_RAMP_CONTROL 8'h25
`define PMS_OFS_BUCK2_TARGET_VOLTAGE_1 8'h29
`define PMS_OFS_BUCK2_TARGET_VOLTAGE_2 8'h2a
`define PMS_OFS_BUCK2_RAMP_CONTROL 8'h2b
`define PMS_OFS_BUCK_FUNCTION 8'h38
`define PMS_OFS_L1VC 8'h39
`define PMS_OFS_L2VC 8'h3a

`define PMS_SYS_RST 8'h28
`define PMS_SYS_WMASK 8'h77
`define PMS_SYS_FIXED 8'h08
`define PMS_EN_RST 8'h75
`define PMS_EN_WMASK 8'h55
`define PMS_EN_FIXED 8'h20

`define PMS_ISR_HOT 1
`define PMS_SYS_PRESET_LSB 4
`define PMS_SYS_BUCK2_FORCE_PWM 2
`define PMS_SYS_BUCK1_FORCE_PWM 1
`define PMS_SYS_EXTCLK 0
`define PMS_EN_BUCK1 0
`define PMS_EN_BUCK2 2
`define PMS_EN_LDO1 4
`define PMS_EN_LDO2 6

`define PMS_CLK_PERIOD_NS 100
`define PMS_DEGLITCH_US 1000
`define PMS_HALF_MS_US 500
`define PMS_DEGLITCH_CYC (`PMS_DEGLITCH_US * 1000 / `PMS_CLK_PERIOD_NS)
`define PMS_HALF_MS_CYC (`PMS_HALF_MS_US * 1000 / `PMS_CLK_PERIOD_NS)

// Delay choices in half-millisecond ticks: 1, 1.5, 2, 3, 6, 11 ms
`define PMS_DLY_1 5'h02
`define PMS_DLY_1P5 5'h03
`define PMS_DLY_2 5'h04
`define PMS_DLY_3 5'h06
`define PMS_DLY_6 5'h0c
`define PMS_DLY_11 5'h16
`define PMS_SEQ_END 5'h16

`endif

/* rtl/pms_pkg.sv */
// Types of the power sequencer and its serial register port.
package pms_pkg;

    typedef enum logic [1:0] {
        PMS_SEQ_IDLE = 2'b00,
        PMS_SEQ_UP = 2'b01,
        PMS_SEQ_DOWN = 2'b10
    } pms_seq_st_t;

    typedef enum logic [2:0] {
        PMS_I2C_IDLE = 3'b000,
        PMS_I2C_RX = 3'b001,
        PMS_I2C_ACK = 3'b010,
        PMS_I2C_TX = 3'b011,
        PMS_I2C_TXACK = 3'b100
    } pms_i2c_st_t;

    // Delay codes index the six allowed times
    typedef enum logic [2:0] {
        PMS_D1 = 3'b000,
        PMS_D1P5 = 3'b001,
        PMS_D2 = 3'b010,
        PMS_D3 = 3'b011,
        PMS_D6 = 3'b100,
        PMS_D11 = 3'b101
    } pms_dcode_t;

    typedef struct packed {
        logic [4:0] ldo2;
        logic [4:0] ldo1;
        logic [4:0] buck2;
        logic [4:0] buck1;
    } pms_dly_t;

    typedef struct packed {
        logic ldo2;
        logic ldo1;
        logic buck2;
        logic buck1;
    } pms_reg4_t;

endpackage : pms_pkg

/* rtl/pms_top.sv */
// Power sequencer with its serial register slave.
`timescale 1ns/10ps
`include "pms_defines.svh"

module pms_top #(
    parameter int DEGLITCH_CYC = `PMS_DEGLITCH_CYC,
    parameter int HALF_MS_CYC = `PMS_HALF_MS_CYC
) (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Serial bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    // Sequencing pins
    input wire logic i_seq_trig,
    input wire pms_pkg::pms_reg4_t i_ext_en,
    input wire logic i_temp_hot,
    // Regulator control
    output pms_pkg::pms_reg4_t o_reg_on,
    output logic o_buck1_force_pwm,
    output logic o_buck2_force_pwm,
    output logic o_ext_clock_select
);

    // Maps a delay code to half-millisecond ticks
    function automatic logic [4:0] code_ticks(
        input pms_pkg::pms_dcode_t c);
        unique case (c)
            pms_pkg::PMS_D1: code_ticks = `PMS_DLY_1;
            pms_pkg::PMS_D1P5: code_ticks = `PMS_DLY_1P5;
            pms_pkg::PMS_D2: code_ticks = `PMS_DLY_2;
            pms_pkg::PMS_D3: code_ticks = `PMS_DLY_3;
            pms_pkg::PMS_D6: code_ticks = `PMS_DLY_6;
            default: code_ticks = `PMS_DLY_11;
        endcase
    endfunction : code_ticks

    function automatic pms_pkg::pms_dly_t mk_dly(
        input pms_pkg::pms_dcode_t b1,
        input pms_pkg::pms_dcode_t b2,
        input pms_pkg::pms_dcode_t l1,
        input pms_pkg::pms_dcode_t l2);
        mk_dly.buck1 = code_ticks(b1);
        mk_dly.buck2 = code_ticks(b2);
        mk_dly.ldo1 = code_ticks(l1);
        mk_dly.ldo2 = code_ticks(l2);
    endfunction : mk_dly

    // Preset to the four regulator delays
    function automatic pms_pkg::pms_dly_t preset_dly(
        input logic [2:0] p);
        unique case (p)
            3'h0: preset_dly = mk_dly(pms_pkg::PMS_D1,
                pms_pkg::PMS_D1, pms_pkg::PMS_D1, pms_pkg::PMS_D1);
            3'h1: preset_dly = mk_dly(pms_pkg::PMS_D1,
                pms_pkg::PMS_D1P5, pms_pkg::PMS_D2, pms_pkg::PMS_D2);
            3'h2: preset_dly = mk_dly(pms_pkg::PMS_D1P5,
                pms_pkg::PMS_D2, pms_pkg::PMS_D3, pms_pkg::PMS_D6);
            3'h3: preset_dly = mk_dly(pms_pkg::PMS_D1P5,
                pms_pkg::PMS_D2, pms_pkg::PMS_D1, pms_pkg::PMS_D1);
            3'h4: preset_dly = mk_dly(pms_pkg::PMS_D1P5,
                pms_pkg::PMS_D2, pms_pkg::PMS_D3, pms_pkg::PMS_D6);
            3'h5: preset_dly = mk_dly(pms_pkg::PMS_D1P5,
                pms_pkg::PMS_D1P5, pms_pkg::PMS_D2, pms_pkg::PMS_D2);
            3'h6: preset_dly = mk_dly(pms_pkg::PMS_D3,
                pms_pkg::PMS_D2, pms_pkg::PMS_D1, pms_pkg::PMS_D1P5);
            default: preset_dly = mk_dly(pms_pkg::PMS_D2,
                pms_pkg::PMS_D3, pms_pkg::PMS_D6, pms_pkg::PMS_D11);
        endcase
    endfunction : preset_dly

    // Index of a plain storage register, 15 when none
    function automatic logic [3:0] mem_idx(input logic [7:0] a);
        unique case (a)
            `PMS_OFS_VCC: mem_idx = 4'h0;
            `PMS_OFS_BUCK1_TARGET_VOLTAGE_1: mem_idx = 4'h1;
            `PMS_OFS_BUCK1_TARGET_VOLTAGE_2: mem_idx = 4'h2;
            `PMS_OFS_BUCK1_RAMP_CONTROL: mem_idx = 4'h3;
            `PMS_OFS_BUCK2_TARGET_VOLTAGE_1: mem_idx = 4'h4;
            `PMS_OFS_BUCK2_TARGET_VOLTAGE_2: mem_idx = 4'h5;
            `PMS_OFS_BUCK2_RAMP_CONTROL: mem_idx = 4'h6;
            `PMS_OFS_BUCK_FUNCTION: mem_idx = 4'h7;
            `PMS_OFS_L1VC: mem_idx = 4'h8;
            `PMS_OFS_L2VC: mem_idx = 4'h9;
            default: mem_idx = 4'hf;
        endcase
    endfunction : mem_idx

    // ---- Input synchronisers
    logic [7:0] pin_raw;
    logic [7:0] s1_r;
    logic [7:0] s2_r;
    logic [1:0] bus_prev_r;
    assign pin_raw = {i_temp_hot, i_ext_en, i_seq_trig, i_sda, i_scl};

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r <= 8'h03;
            s2_r <= 8'h03;
            bus_prev_r <= 2'h3;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            bus_prev_r <= s2_r[1:0];
        end
    end

    logic scl_s;
    logic sda_s;
    logic trig_s;
    logic hot_s;
    pms_pkg::pms_reg4_t ext_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_s = s2_r[0];
    assign sda_s = s2_r[1];
    assign trig_s = s2_r[2];
    assign ext_s = s2_r[6:3];
    assign hot_s = s2_r[7];
    assign scl_rise = scl_s & ~bus_prev_r[0];
    assign scl_fall = ~scl_s & bus_prev_r[0];
    assign bus_start = scl_s & bus_prev_r[0] & bus_prev_r[1] & ~sda_s;
    assign bus_stop = scl_s & bus_prev_r[0] & ~bus_prev_r[1] & sda_s;

    // ---- Trigger deglitch
    logic trig_q_r;
    logic trig_q_nxt;
    logic [15:0] dg_cnt_r;
    logic [15:0] dg_cnt_nxt;
    logic up_r;
    logic up_nxt;
    logic dn_r;
    logic dn_nxt;

    always_comb begin
        trig_q_nxt = trig_q_r;
        dg_cnt_nxt = 16'h0000;
        up_nxt = 1'b0;
        dn_nxt = 1'b0;
        if (trig_s != trig_q_r) begin
            dg_cnt_nxt = dg_cnt_r + 16'h0001;
            if (dg_cnt_r == 16'(DEGLITCH_CYC - 1)) begin
                dg_cnt_nxt = 16'h0000;
                trig_q_nxt = trig_s;
                up_nxt = trig_s;
                dn_nxt = ~trig_s;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_q_r <= 1'b0;
            dg_cnt_r <= 16'h0000;
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end else begin
            trig_q_r <= trig_q_nxt;
            dg_cnt_r <= dg_cnt_nxt;
            up_r <= up_nxt;
            dn_r <= dn_nxt;
        end
    end

    // ---- Registers
    logic [7:0] sys_r;
    logic [7:0] sys_nxt;
    logic [7:0] en_r;
    logic [7:0] en_nxt;
    logic [7:0] mem_r [10];
    logic [7:0] mem_nxt [10];
    logic wr_req;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] stat_val;
    logic [3:0] rd_idx;
    logic [3:0] wr_idx;
    logic [7:0] ptr_r;
    pms_pkg::pms_reg4_t on_r;

    assign stat_val = {on_r.buck1 & on_r.buck2, on_r.ldo1 & on_r.ldo2,
        on_r.ldo2, on_r.ldo1, 1'b0, on_r.buck2, 1'b0, on_r.buck1};
    assign rd_idx = mem_idx(ptr_r);
    assign wr_idx = mem_idx(ptr_r);

    always_comb begin
        unique case (ptr_r)
            `PMS_OFS_ISR: begin
                rd_data = 8'h00;
                rd_data[`PMS_ISR_HOT] = hot_s;
            end
            `PMS_OFS_SYS: rd_data = sys_r;
            `PMS_OFS_EN: rd_data = en_r;
            `PMS_OFS_STAT: rd_data = stat_val;
            default: rd_data = (rd_idx == 4'hf) ? 8'h00 : mem_r[rd_idx];
        endcase
    end

    always_comb begin
        sys_nxt = sys_r;
        en_nxt = en_r;
        mem_nxt = mem_r;
        if (wr_req) begin
            if (ptr_r == `PMS_OFS_SYS) begin
                sys_nxt = (wr_data & `PMS_SYS_WMASK) | `PMS_SYS_FIXED;
            end else if (ptr_r == `PMS_OFS_EN) begin
                en_nxt = (wr_data & `PMS_EN_WMASK) | `PMS_EN_FIXED;
            end else if (wr_idx != 4'hf) begin
                mem_nxt[wr_idx] = wr_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sys_r <= `PMS_SYS_RST;
            en_r <= `PMS_EN_RST;
            for (int i = 0; i < 10; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else begin
            sys_r <= sys_nxt;
            en_r <= en_nxt;
            mem_r <= mem_nxt;
        end
    end

    // ---- Sequencer
    pms_pkg::pms_seq_st_t seq_st_r;
    pms_pkg::pms_seq_st_t seq_st_nxt;
    logic [15:0] pre_r;
    logic [15:0] pre_nxt;
    logic [4:0] tick_r;
    logic [4:0] tick_nxt;
    pms_pkg::pms_dly_t dly_r;
    pms_pkg::pms_dly_t dly_nxt;
    pms_pkg::pms_reg4_t seq_on_r;
    pms_pkg::pms_reg4_t seq_on_nxt;
    logic lvl;

    always_comb begin
        seq_st_nxt = seq_st_r;
        pre_nxt = pre_r;
        tick_nxt = tick_r;
        dly_nxt = dly_r;
        seq_on_nxt = seq_on_r;
        lvl = (seq_st_r == pms_pkg::PMS_SEQ_UP);
        if (up_r || dn_r) begin
            seq_st_nxt = up_r ? pms_pkg::PMS_SEQ_UP
                : pms_pkg::PMS_SEQ_DOWN;
            pre_nxt = 16'h0000;
            tick_nxt = 5'h00;
            // Shutdown reuses the power-on delays
            dly_nxt = preset_dly(
                sys_r[`PMS_SYS_PRESET_LSB +: 3]);
        end else if (seq_st_r != pms_pkg::PMS_SEQ_IDLE) begin
            if (tick_r >= dly_r.buck1) seq_on_nxt.buck1 = lvl;
            if (tick_r >= dly_r.buck2) seq_on_nxt.buck2 = lvl;
            if (tick_r >= dly_r.ldo1) seq_on_nxt.ldo1 = lvl;
            if (tick_r >= dly_r.ldo2) seq_on_nxt.ldo2 = lvl;
            pre_nxt = pre_r + 16'h0001;
            if (pre_r == 16'(HALF_MS_CYC - 1)) begin
                pre_nxt = 16'h0000;
                tick_nxt = tick_r + 5'h01;
            end
            if (tick_r >= `PMS_SEQ_END) begin
                seq_st_nxt = pms_pkg::PMS_SEQ_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            seq_st_r <= pms_pkg::PMS_SEQ_IDLE;
            pre_r <= 16'h0000;
            tick_r <= 5'h00;
            dly_r <= '0;
            seq_on_r <= '0;
        end else begin
            seq_st_r <= seq_st_nxt;
            pre_r <= pre_nxt;
            tick_r <= tick_nxt;
            dly_r <= dly_nxt;
            seq_on_r <= seq_on_nxt;
        end
    end

    // ---- Regulator outputs
    pms_pkg::pms_reg4_t reg_en;
    pms_pkg::pms_reg4_t on_nxt;
    assign reg_en = {en_r[`PMS_EN_LDO2], en_r[`PMS_EN_LDO1],
        en_r[`PMS_EN_BUCK2], en_r[`PMS_EN_BUCK1]};

    always_comb begin
        // Pins count only while the accepted trigger is low
        if (trig_q_r) begin
            on_nxt = reg_en & seq_on_r;
        end else begin
            on_nxt = reg_en & (ext_s | seq_on_r);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            on_r <= '0;
            o_buck1_force_pwm <= 1'b0;
            o_buck2_force_pwm <= 1'b0;
            o_ext_clock_select <= 1'b0;
        end else begin
            on_r <= on_nxt;
            o_buck1_force_pwm <= sys_r[`PMS_SYS_BUCK1_FORCE_PWM];
            o_buck2_force_pwm <= sys_r[`PMS_SYS_BUCK2_FORCE_PWM];
            o_ext_clock_select <= sys_r[`PMS_SYS_EXTCLK];
        end
    end
    assign o_reg_on = on_r;

    // ---- Serial slave
    pms_pkg::pms_i2c_st_t st_r;
    pms_pkg::pms_i2c_st_t st_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [1:0] idx_r;
    logic [1:0] idx_nxt;
    logic rw_r;
    logic rw_nxt;
    logic [7:0] ptr_nxt;
    logic oe_r;
    logic oe_nxt;
    logic mack_r;
    logic mack_nxt;

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        idx_nxt = idx_r;
        rw_nxt = rw_r;
        ptr_nxt = ptr_r;
        oe_nxt = oe_r;
        mack_nxt = mack_r;
        wr_req = 1'b0;
        wr_data = sh_r;
        if (bus_start) begin
            st_nxt = pms_pkg::PMS_I2C_RX;
            bit_nxt = 4'h0;
            idx_nxt = 2'h0;
            oe_nxt = 1'b0;
        end else if (bus_stop) begin
            st_nxt = pms_pkg::PMS_I2C_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (st_r)
                pms_pkg::PMS_I2C_IDLE: begin
                    oe_nxt = 1'b0;
                end
                pms_pkg::PMS_I2C_RX: begin
                    if (scl_rise && bit_r != 4'h8) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        bit_nxt = 4'h0;
                        st_nxt = pms_pkg::PMS_I2C_ACK;
                        oe_nxt = 1'b1;
                        if (idx_r == 2'h0) begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] != `PMS_SLAVE_ADDR) begin
                                st_nxt = pms_pkg::PMS_I2C_IDLE;
                                oe_nxt = 1'b0;
                            end
                        end else if (idx_r == 2'h1) begin
                            ptr_nxt = sh_r;
                        end else begin
                            wr_req = 1'b1;
                        end
                    end
                end
                pms_pkg::PMS_I2C_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        bit_nxt = 4'h0;
                        if (idx_r == 2'h0 && rw_r) begin
                            st_nxt = pms_pkg::PMS_I2C_TX;
                            sh_nxt = rd_data;
                            oe_nxt = ~rd_data[7];
                        end else begin
                            st_nxt = pms_pkg::PMS_I2C_RX;
                            idx_nxt = (idx_r == 2'h0) ? 2'h1 : 2'h2;
                        end
                    end
                end
                pms_pkg::PMS_I2C_TX: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h7) begin
                            oe_nxt = 1'b0;
                            st_nxt = pms_pkg::PMS_I2C_TXACK;
                        end else begin
                            bit_nxt = bit_r + 4'h1;
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                        end
                    end
                end
                pms_pkg::PMS_I2C_TXACK: begin
                    if (scl_rise) begin
                        mack_nxt = ~sda_s;
                    end else if (scl_fall) begin
                        bit_nxt = 4'h0;
                        if (mack_r) begin
                            st_nxt = pms_pkg::PMS_I2C_TX;
                            sh_nxt = rd_data;
                            oe_nxt = ~rd_data[7];
                        end else begin
                            st_nxt = pms_pkg::PMS_I2C_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt = pms_pkg::PMS_I2C_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r <= pms_pkg::PMS_I2C_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            idx_r <= 2'h0;
            rw_r <= 1'b0;
            ptr_r <= 8'h00;
            oe_r <= 1'b0;
            mack_r <= 1'b0;
            o_sda_o <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            idx_r <= idx_nxt;
            rw_r <= rw_nxt;
            ptr_r <= ptr_nxt;
            oe_r <= oe_nxt;
            mack_r <= mack_nxt;
            o_sda_o <= 1'b0;
        end
    end
    assign o_sda_oe = oe_r;

endmodule : pms_top

/* verif/pms_checker.sv */
// Assertions on the pins of the sequencer and its serial port.
`timescale 1ns/10ps
module pms_checker #(
    parameter int DEGLITCH_CYC = 20,
    parameter int HALF_MS_CYC = 10
) (
    // Clock, reset and pins
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_seq_trig,
    // Outputs watched
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire pms_pkg::pms_reg4_t o_reg_on,
    input wire logic o_buck1_force_pwm,
    input wire logic o_buck2_force_pwm,
    input wire logic o_ext_clock_select
);
    localparam int LO = DEGLITCH_CYC + 4;
    localparam int HI = DEGLITCH_CYC + 2 * HALF_MS_CYC - 2;
    logic [15:0] hi_r;
    logic [15:0] lo_r;
    logic [3:0] sh_r;
    // Run lengths of trigger high, trigger low and SCL high
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hi_r <= '0;
            lo_r <= '0;
            sh_r <= '0;
        end else begin
            hi_r <= i_seq_trig ? hi_r + 16'(hi_r != '1) : '0;
            lo_r <= i_seq_trig ? '0 : lo_r + 16'(lo_r != '1);
            sh_r <= i_scl ? sh_r + 4'(sh_r != '1) : '0;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence s_scl_high2;
        i_scl ##1 i_scl;
    endsequence
    sequence s_up_early;
        i_seq_trig && hi_r > LO && hi_r < HI;
    endsequence
    reset_clear_a: assert property ($rose(i_rstn) |-> o_reg_on == '0 &&
        !o_sda_oe && !o_buck1_force_pwm && !o_buck2_force_pwm &&
        !o_ext_clock_select) else $error("outputs not cleared by reset");
    sda_open_a: assert property (o_sda_o == 1'b0)
        else $error("sda drive value not low");
    pin_hold_a: assert property (s_scl_high2 |-> $stable(o_sda_oe))
        else $error("sda moved while scl high");
    drive_lag_a: assert property ($changed(o_sda_oe) |->
        !i_scl && !$past(i_scl)) else $error("sda moved too near scl");
    idle_free_a: assert property (sh_r >= 4'h8 |-> !o_sda_oe)
        else $error("sda driven on idle bus");
    seq_early_a: assert property (s_up_early |->
        (4'(o_reg_on) & ~4'($past(o_reg_on))) == 4'h0)
        else $error("regulator on before shortest delay");
    seq_shut_a: assert property (!i_seq_trig && lo_r > LO && lo_r < HI
        |-> (~4'(o_reg_on) & 4'($past(o_reg_on))) == 4'h0)
        else $error("regulator off before shortest delay");
    ctl_quiet_a: assert property ($changed({o_buck1_force_pwm,
        o_buck2_force_pwm, o_ext_clock_select}) |-> !$past(i_scl))
        else $error("control bit changed outside a write");
endmodule : pms_checker

bind pms_top pms_checker #(.DEGLITCH_CYC(DEGLITCH_CYC),
    .HALF_MS_CYC(HALF_MS_CYC)) chk_i (.i_clk, .i_rstn, .i_scl, .i_seq_trig,
    .o_sda_o, .o_sda_oe, .o_reg_on, .o_buck1_force_pwm, .o_buck2_force_pwm,
    .o_ext_clock_select);

/* verif/pms_i2c_host.sv */
// I2C host model that masters the serial register port.
`timescale 1ns/10ps
module pms_i2c_host (
    // Bus lines
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Calls start on a falling clock edge so pins never move on a sample
    task put_bit(input logic b);
        #200 o_sda_low = !b;
        #300 o_scl = 1'b1;
        #300 o_scl = 1'b0;
    endtask : put_bit
    task get_bit(output logic b);
        #200 o_sda_low = 1'b0;
        #300 o_scl = 1'b1;
        #100 b = i_sda;
        #200 o_scl = 1'b0;
    endtask : get_bit
    task start();
        #200 o_sda_low = 1'b0;
        #200 o_scl = 1'b1;
        #200 o_sda_low = 1'b1;
        #200 o_scl = 1'b0;
    endtask : start
    task stop();
        #200 o_sda_low = 1'b1;
        #200 o_scl = 1'b1;
        #200 o_sda_low = 1'b0;
    endtask : stop
    task send(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ack = !a;
    endtask : send
    task wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
        output logic ok);
        logic a0, a1, a2;
        start();
        send({dev, 1'b0}, a0);
        send(ofs, a1);
        send(dat, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : wr
    task rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        send({7'h60, 1'b0}, a0);
        send(ofs, a1);
        start();
        send({7'h60, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(1'b1);
        stop();
        ok = a0 & a1 & a2;
    endtask : rd
endmodule : pms_i2c_host

/* verif/pms_top_bench.sv */
// Self-checking bench of the power sequencer and its register port.
`timescale 1ns/10ps
module pms_top_bench;
    localparam int DG = 20;
    localparam int HM = 10;
    logic i_clk, i_rstn, i_seq_trig, i_temp_hot, i_scl, sda_low, ok;
    logic o_sda_o, o_sda_oe;
    logic o_buck1_force_pwm, o_buck2_force_pwm, o_ext_clock_select;
    pms_pkg::pms_reg4_t i_ext_en, o_reg_on;
    wire logic i_sda;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    // Delays of buck1, buck2, ldo1, ldo2 in half-millisecond ticks
    int tbl[8][4] = '{'{2, 2, 2, 2}, '{2, 3, 4, 4}, '{3, 4, 6, 12},
        '{3, 4, 2, 2}, '{3, 4, 6, 12}, '{3, 3, 4, 4}, '{6, 4, 2, 3},
        '{4, 6, 12, 22}};
    assign i_sda = sda_low ? 1'b0 : (o_sda_oe ? o_sda_o : 1'b1);
    pms_top #(.DEGLITCH_CYC(DG), .HALF_MS_CYC(HM)) dut (.i_clk, .i_rstn,
        .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .i_seq_trig, .i_ext_en,
        .i_temp_hot, .o_reg_on, .o_buck1_force_pwm, .o_buck2_force_pwm,
        .o_ext_clock_select);
    pms_i2c_host host (.i_sda, .o_scl(i_scl), .o_sda_low(sda_low));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = !i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
    end
    task close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] ofs, input logic [7:0] dat);
        @(negedge i_clk);
        host.wr(7'h60, ofs, dat, ok);
        chk({7'h00, ok}, 8'h01);
    endtask : wr
    task rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        @(negedge i_clk);
        host.rd(ofs, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rd
    task ctl(input logic [2:0] e);
        chk({5'h00, o_ext_clock_select, o_buck2_force_pwm,
            o_buck1_force_pwm}, {5'h00, e});
    endtask : ctl
    task run_seq(input int p);
        int first[4];
        int e;
        wr(8'h10, 8'h55);
        wr(8'h07, 8'(p << 4));
        for (int up = 1; up >= 0; up--) begin
            first = '{-1, -1, -1, -1};
            @(posedge i_clk) begin
                i_seq_trig <= up[0];
                i_ext_en <= '0;
            end
            for (int n = 1; n <= 400; n++) begin
                @(posedge i_clk);
                // Pins raised after the trigger is accepted must not count
                if (up[0] && n == DG + 4) i_ext_en <= 4'hf;
                #1;
                for (int k = 0; k < 4; k++)
                    if (first[k] < 0 && o_reg_on[k] === up[0]) first[k] = n;
            end
            for (int k = 0; k < 4; k++) begin
                e = DG + tbl[p][k] * HM;
                chk({7'h00, first[k] >= e && first[k] <= e + 8}, 8'h01);
            end
        end
    endtask : run_seq
    initial begin
        i_rstn = 1'b0;
        i_seq_trig = 1'b0;
        i_temp_hot = 1'b0;
        i_ext_en = '0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(8'h07, 8'h28);
        rd(8'h10, 8'h75);
        rd(8'h02, 8'h00);
        ctl(3'h0);
        @(posedge i_clk) i_temp_hot <= 1'b1;
        rd(8'h02, 8'h02);
        $display("test reset and thermal done");
        @(negedge i_clk) host.wr(7'h61, 8'h07, 8'hff, ok);
        chk({7'h00, ok}, 8'h00);
        rd(8'h07, 8'h28);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h7f);
        ctl(3'h7);
        wr(8'h07, 8'h28);
        ctl(3'h0);
        wr(8'h23, 8'ha5);
        rd(8'h23, 8'ha5);
        rd(8'h05, 8'h00);
        $display("test register access done");
        @(posedge i_clk) i_ext_en <= 4'hf;
        repeat (5) @(posedge i_clk);
        chk({4'h0, o_reg_on}, 8'h0f);
        rd(8'h11, 8'hf5);
        wr(8'h10, 8'h00);
        chk({4'h0, o_reg_on}, 8'h00);
        wr(8'h10, 8'h55);
        @(posedge i_clk) i_ext_en <= '0;
        // A trigger pulse shorter than the deglitch time starts nothing
        @(posedge i_clk) i_seq_trig <= 1'b1;
        repeat (DG / 2) @(posedge i_clk);
        i_seq_trig <= 1'b0;
        repeat (DG + 60) @(posedge i_clk);
        chk({4'h0, o_reg_on}, 8'h00);
        $display("test enable pins done");
        for (int p = 0; p < 8; p++) run_seq(p);
        $display("test sequences done");
        @(posedge i_clk) i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(8'h07, 8'h28);
        rd(8'h23, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule : pms_top_bench
